// *** src/prefetch_cfg_pkg.sv ***
package prefetch_cfg_pkg;

    localparam logic [11:0] CACHE_PERIOD_OFS = 12'h0B4;
    localparam logic [11:0] TIMER_FLAGS_OFS  = 12'h0B8;
    localparam logic [11:0] PREFETCH_OFS     = 12'h0BC;
    localparam logic [11:0] CAP_BASE_OFS     = 12'h0C0;
    localparam logic [11:0] CAP_END_OFS      = 12'h0D4;

    localparam logic [31:0] CACHE_PERIOD_RST = 32'h0000_0040;
    localparam logic [31:0] PREFETCH_RST     = 32'h0300_0041;
    localparam logic [31:0] PREFETCH_WMASK   = 32'h07FF_FFFF;

    localparam int DISCARD_BIT   = 2;
    localparam int RETRY_BIT     = 0;
    localparam int PLAIN_SEL_BIT = 26;
    localparam int LINE_SEL_BIT  = 25;
    localparam int MULT_SEL_BIT  = 24;
    localparam int LINE_FAST_LSB = 18;
    localparam int LINE_SLOW_LSB = 12;
    localparam int MULT_FAST_LSB = 6;
    localparam int MULT_SLOW_LSB = 0;

    localparam int THR_W   = 6;
    localparam int BYTES_W = 13;
    localparam int CHUNK_SHIFT = 6;
    localparam logic [BYTES_W-1:0] DWORD_BYTES = 13'h0004;
    localparam logic [BYTES_W-1:0] LINE_BYTES  = 13'h0040;

    localparam logic [1:0] CMD_PLAIN = 2'h0;
    localparam logic [1:0] CMD_LINE  = 2'h1;
    localparam logic [1:0] CMD_MULT  = 2'h2;

endpackage

// *** src/bridge_prefetch_config.sv ***
`timescale 1ns/100ps
module bridge_prefetch_config
    import prefetch_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic               core_clk_i,
    input  wire logic               resetn_i,
    // Configuration access.
    input  wire logic               cfg_wr_i,
    input  wire logic               cfg_rd_i,
    input  wire logic [11:0]        cfg_addr_i,
    input  wire logic [31:0]        cfg_wdata_i,
    input  wire logic [3:0]         cfg_be_i,
    output logic      [31:0]        cfg_rdata_o,
    output logic                    cfg_rvalid_o,
    output logic                    cap_window_o,
    // Timer events and bus speed.
    input  wire logic               discard_timer_expired_i,
    input  wire logic               retry_timer_expired_i,
    input  wire logic               bus_fast_i,
    // Read caching.
    input  wire logic               cache_fill_i,
    output logic                    cache_discard_o,
    // Prefetch request.
    input  wire logic               req_i,
    input  wire logic [1:0]         req_cmd_i,
    output logic                    amt_valid_o,
    output logic [BYTES_W-1:0]      amt_bytes_o
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [31:0] cache_hold_cycles_ff;
    logic [31:0] read_prefetch_config_ff;
    logic        discard_timer_expired_ff;
    logic        retry_timer_expired_ff;
    logic [31:0] hold_cnt_ff;
    logic        holding_ff;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [BYTES_W-1:0] chunk_bytes(
        input logic [THR_W-1:0] f);
        logic [BYTES_W-1:0] n;
        n = {{(BYTES_W-THR_W){1'b0}}, f} + 13'h0001;
        return BYTES_W'(n << CHUNK_SHIFT);
    endfunction

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cache_hold_cycles_ff <= CACHE_PERIOD_RST;
        end else if (cfg_wr_i && cfg_addr_i == CACHE_PERIOD_OFS) begin
            cache_hold_cycles_ff <= be_merge(cache_hold_cycles_ff,
                                             cfg_wdata_i, cfg_be_i);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            read_prefetch_config_ff <= PREFETCH_RST;
        end else if (cfg_wr_i && cfg_addr_i == PREFETCH_OFS) begin
            read_prefetch_config_ff <= be_merge(read_prefetch_config_ff,
                cfg_wdata_i, cfg_be_i) & PREFETCH_WMASK;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            discard_timer_expired_ff <= 1'b0;
        end else begin
            discard_timer_expired_ff <= discard_timer_expired_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            retry_timer_expired_ff <= 1'b0;
        end else begin
            retry_timer_expired_ff <= retry_timer_expired_i;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (cfg_addr_i)
            CACHE_PERIOD_OFS: nxt_rdata = cache_hold_cycles_ff;
            TIMER_FLAGS_OFS: begin
                nxt_rdata[DISCARD_BIT] = discard_timer_expired_ff;
                nxt_rdata[RETRY_BIT]   = retry_timer_expired_ff;
            end
            PREFETCH_OFS: nxt_rdata = read_prefetch_config_ff
                                      & PREFETCH_WMASK;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cfg_rdata_o  <= 32'h0000_0000;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rdata_o  <= cfg_rd_i ? nxt_rdata : 32'h0000_0000;
            cfg_rvalid_o <= cfg_rd_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cap_window_o <= 1'b0;
        end else begin
            cap_window_o <= (cfg_rd_i || cfg_wr_i)
                         && cfg_addr_i >= CAP_BASE_OFS
                         && cfg_addr_i <  CAP_END_OFS;
        end
    end

    // ****************************************************************
    // Short-term cache lifetime
    // ****************************************************************
    // A new fill restarts the count, so data is never dropped early.
    // Lifetime counter.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            hold_cnt_ff     <= 32'h0000_0000;
            holding_ff      <= 1'b0;
            cache_discard_o <= 1'b0;
        end else if (cache_fill_i) begin
            hold_cnt_ff     <= 32'h0000_0000;
            holding_ff      <= 1'b1;
            cache_discard_o <= 1'b0;
        end else if (holding_ff) begin
            hold_cnt_ff     <= hold_cnt_ff + 32'h0000_0001;
            if (hold_cnt_ff + 32'h0000_0001 >= cache_hold_cycles_ff) begin
                holding_ff      <= 1'b0;
                cache_discard_o <= 1'b1;
            end
        end else begin
            cache_discard_o <= 1'b0;
        end
    end

    // ****************************************************************
    // Prefetch amount
    // ****************************************************************
    logic [THR_W-1:0]   line_thr;
    logic [THR_W-1:0]   mult_thr;
    logic [BYTES_W-1:0] nxt_amt;
    always_comb begin
        line_thr = bus_fast_i
            ? read_prefetch_config_ff[LINE_FAST_LSB +: THR_W]
            : read_prefetch_config_ff[LINE_SLOW_LSB +: THR_W];
        mult_thr = bus_fast_i
            ? read_prefetch_config_ff[MULT_FAST_LSB +: THR_W]
            : read_prefetch_config_ff[MULT_SLOW_LSB +: THR_W];
        case (req_cmd_i)
            CMD_PLAIN: nxt_amt = read_prefetch_config_ff[PLAIN_SEL_BIT]
                               ? chunk_bytes(line_thr) : DWORD_BYTES;
            CMD_LINE:  nxt_amt = read_prefetch_config_ff[LINE_SEL_BIT]
                               ? chunk_bytes(line_thr) : LINE_BYTES;
            CMD_MULT:  nxt_amt = read_prefetch_config_ff[MULT_SEL_BIT]
                               ? chunk_bytes(mult_thr)
                               : BYTES_W'(LINE_BYTES << 1);
            default:   nxt_amt = DWORD_BYTES;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            amt_valid_o <= 1'b0;
            amt_bytes_o <= '0;
        end else begin
            amt_valid_o <= req_i;
            amt_bytes_o <= req_i ? nxt_amt : amt_bytes_o;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    period_reset_a: assert property (@(posedge core_clk_i)
        $rose(resetn_i) |-> cache_hold_cycles_ff == CACHE_PERIOD_RST)
        else $error("cache period reset value wrong");

    discard_flag_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) cfg_rd_i && cfg_addr_i == TIMER_FLAGS_OFS
        |=> cfg_rdata_o[DISCARD_BIT] == $past(discard_timer_expired_ff))
        else $error("discard flag read wrong");

    retry_flag_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) cfg_rd_i && cfg_addr_i == TIMER_FLAGS_OFS
        |=> cfg_rdata_o[RETRY_BIT] == $past(retry_timer_expired_ff))
        else $error("retry flag read wrong");

    status_reserved_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) cfg_rd_i && cfg_addr_i == TIMER_FLAGS_OFS
        |=> cfg_rdata_o[31:3] == '0 && !cfg_rdata_o[1])
        else $error("status reserved bits nonzero");

    ctrl_reserved_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) cfg_rd_i && cfg_addr_i == PREFETCH_OFS
        |=> cfg_rdata_o[31:27] == '0)
        else $error("control reserved bits nonzero");

    mult_default_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        req_i && req_cmd_i == CMD_MULT
        && !read_prefetch_config_ff[MULT_SEL_BIT]
        |=> amt_valid_o && amt_bytes_o == 13'h0080)
        else $error("read multiple default amount wrong");

    plain_dword_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        req_i && req_cmd_i == CMD_PLAIN
        && !read_prefetch_config_ff[PLAIN_SEL_BIT]
        |=> amt_bytes_o == 13'h0004)
        else $error("plain read amount wrong");

    cache_expire_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        cache_fill_i && cache_hold_cycles_ff == 32'h0000_0002
        ##1 !cache_fill_i ##1 !cache_fill_i |=> cache_discard_o)
        else $error("cache discard late or missing");

    period_lane_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        cfg_wr_i && cfg_addr_i == CACHE_PERIOD_OFS && cfg_be_i[0]
        |=> cache_hold_cycles_ff[7:0] == $past(cfg_wdata_i[7:0]))
        else $error("cache period low byte not written");

    ctrl_write_mask_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        cfg_wr_i && cfg_addr_i == PREFETCH_OFS
        |=> (read_prefetch_config_ff & ~PREFETCH_WMASK) == '0)
        else $error("reserved control bits were written");

    cap_window_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (cfg_rd_i || cfg_wr_i) && cfg_addr_i >= CAP_BASE_OFS
        && cfg_addr_i < CAP_END_OFS
        |=> cap_window_o)
        else $error("capability window not flagged");

    line_default_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        req_i && req_cmd_i == CMD_LINE
        && !read_prefetch_config_ff[LINE_SEL_BIT]
        |=> amt_valid_o && amt_bytes_o == LINE_BYTES)
        else $error("read line default amount wrong");

    // Expected amounts use a product, so a broken shift decode is caught.
    line_fast_thr_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        req_i && req_cmd_i == CMD_LINE && bus_fast_i
        && read_prefetch_config_ff[LINE_SEL_BIT]
        |=> amt_bytes_o == (BYTES_W'($past(read_prefetch_config_ff[
            LINE_FAST_LSB +: THR_W])) + 13'h0001) * LINE_BYTES)
        else $error("fast line threshold amount wrong");

    plain_slow_thr_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        req_i && req_cmd_i == CMD_PLAIN && !bus_fast_i
        && read_prefetch_config_ff[PLAIN_SEL_BIT]
        |=> amt_bytes_o == (BYTES_W'($past(read_prefetch_config_ff[
            LINE_SLOW_LSB +: THR_W])) + 13'h0001) * LINE_BYTES)
        else $error("slow plain read threshold amount wrong");

    mult_fast_thr_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        req_i && req_cmd_i == CMD_MULT && bus_fast_i
        && read_prefetch_config_ff[MULT_SEL_BIT]
        |=> amt_bytes_o == (BYTES_W'($past(read_prefetch_config_ff[
            MULT_FAST_LSB +: THR_W])) + 13'h0001) * LINE_BYTES)
        else $error("fast read multiple threshold amount wrong");

    mult_slow_thr_a: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        req_i && req_cmd_i == CMD_MULT && !bus_fast_i
        && read_prefetch_config_ff[MULT_SEL_BIT]
        |=> amt_bytes_o == (BYTES_W'($past(read_prefetch_config_ff[
            MULT_SLOW_LSB +: THR_W])) + 13'h0001) * LINE_BYTES)
        else $error("slow read multiple threshold amount wrong");

endmodule

// *** bench/read_master.sv ***
`timescale 1ns/100ps
module read_master (
    // Clock.
    input  wire logic       core_clk_i,
    // Read request side.
    output logic            req_o,
    output logic [1:0]      cmd_o
);
    initial begin
        req_o = 1'b0;
        cmd_o = 2'h3;
    end
    // The command lines are inverted after each pulse, so a design that
    // samples them outside the request cycle sees a wrong command.
    task automatic issue(input logic [1:0] cmd);
        @(posedge core_clk_i);
        req_o <= 1'b1;
        cmd_o <= cmd;
        @(posedge core_clk_i);
        req_o <= 1'b0;
        cmd_o <= ~cmd;
    endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import prefetch_cfg_pkg::*;
    logic               clk, resetn, wr, rd, rvalid, capwin;
    logic               dis_exp, ret_exp, fast, fill, discard, req, amt_v;
    logic [11:0]        addr;
    logic [31:0]        wdata, rdata;
    logic [3:0]         be;
    logic [1:0]         cmd;
    logic [12:0]        amt_b;
    int                 n_errors, samples_checked, n;
    logic [31:0]        pcfg [3] = '{32'h0300_0041, 32'h07FC_50BF,
                                     32'h00FC_50BF};
    logic [12:0]        eb [3][2][3] = '{
        '{'{13'h004, 13'h040, 13'h080}, '{13'h004, 13'h040, 13'h080}},
        '{'{13'h180, 13'h180, 13'h1000}, '{13'h1000, 13'h1000, 13'h0C0}},
        '{'{13'h004, 13'h040, 13'h080}, '{13'h004, 13'h040, 13'h080}}};

    bridge_prefetch_config i_dut (.core_clk_i(clk), .resetn_i(resetn),
        .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr),
        .cfg_wdata_i(wdata), .cfg_be_i(be), .cfg_rdata_o(rdata),
        .cfg_rvalid_o(rvalid), .cap_window_o(capwin),
        .discard_timer_expired_i(dis_exp), .retry_timer_expired_i(ret_exp),
        .bus_fast_i(fast), .cache_fill_i(fill), .cache_discard_o(discard),
        .req_i(req), .req_cmd_i(cmd), .amt_valid_o(amt_v),
        .amt_bytes_o(amt_b));
    read_master u_master (.core_clk_i(clk), .req_o(req), .cmd_o(cmd));

    // **********************************************************
    // Access and checking tasks
    // **********************************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cfg_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [3:0] b);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        be <= b;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    // Answer and window flag are looked at in their single valid cycle.
    task automatic cfg_read(input logic [11:0] a, input logic [31:0] exp,
                            input logic cap);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        check("rvalid", {31'h0, rvalid}, 32'h1);
        check("rdata", rdata, exp);
        check("cap_window", {31'h0, capwin}, {31'h0, cap});
    endtask

    task automatic prefetch(input logic [1:0] c, input logic f,
                            input logic [12:0] exp);
        @(posedge clk);
        fast <= f;
        u_master.issue(c);
        #1;
        check("amt_valid", {31'h0, amt_v}, 32'h1);
        check("amt_bytes", {19'h0, amt_b}, {19'h0, exp});
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // **********************************************************
    // Main sequence
    // **********************************************************
    initial begin
        {resetn, wr, rd, dis_exp, ret_exp, fast, fill} = 7'h00;
        addr = 12'h000;
        wdata = 32'h0;
        be = 4'hF;
        n_errors = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        cfg_read(CACHE_PERIOD_OFS, 32'h0000_0040, 1'b0);
        cfg_read(TIMER_FLAGS_OFS, 32'h0000_0000, 1'b0);
        cfg_read(PREFETCH_OFS, 32'h0300_0041, 1'b0);
        cfg_read(12'h0B0, 32'h0000_0000, 1'b0);
        cfg_read(12'h0C0, 32'h0000_0000, 1'b1);
        cfg_read(12'h0D0, 32'h0000_0000, 1'b1);
        cfg_read(12'h0D4, 32'h0000_0000, 1'b0);
        cfg_write(TIMER_FLAGS_OFS, 32'hFFFF_FFFF, 4'hF);
        cfg_read(TIMER_FLAGS_OFS, 32'h0000_0000, 1'b0);
        cfg_write(PREFETCH_OFS, 32'hFFFF_FFFF, 4'hF);
        cfg_read(PREFETCH_OFS, 32'h07FF_FFFF, 1'b0);
        cfg_write(CACHE_PERIOD_OFS, 32'hFFFF_FF02, 4'h1);
        cfg_read(CACHE_PERIOD_OFS, 32'h0000_0002, 1'b0);
        @(posedge clk);
        dis_exp <= 1'b1;
        cfg_read(TIMER_FLAGS_OFS, 32'h0000_0004, 1'b0);
        @(posedge clk);
        dis_exp <= 1'b0;
        ret_exp <= 1'b1;
        cfg_read(TIMER_FLAGS_OFS, 32'h0000_0001, 1'b0);
        // A period of two raises discard at the second edge after the fill.
        @(posedge clk);
        fill <= 1'b1;
        @(posedge clk);
        fill <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (discard !== 1'b1 && n < 50);
        if (n >= 50) begin
            check("discard_wait", 32'h0, 32'h1);
        end else begin
            check("discard_edges", n, 32'h2);
        end
        for (int i = 0; i < 3; i++) begin
            cfg_write(PREFETCH_OFS, pcfg[i], 4'hF);
            for (int s = 0; s < 2; s++) begin
                for (int c = 0; c < 3; c++) begin
                    prefetch(c[1:0], s[0], eb[i][s][c]);
                end
            end
        end
        cfg_write(PREFETCH_OFS, pcfg[1], 4'hF);
        prefetch(2'h3, 1'b1, DWORD_BYTES);
        complete_run();
    end
endmodule
